// ### cbiu_mem_model.sv
// cbiu_mem_model: memory and i/o slave with a wait-state generator
// assumes: same clock as the unit; minimum-mode strobes drive it
`timescale 1ns/1ps
`default_nettype none
module cbiu_mem_model (
    input wire logic clk,
    input wire logic ale,
    input wire logic [19:0] busPins,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n,
    input wire logic [3:0] waitCycles,
    output logic [7:0] adIn,
    output logic readyPin,
    output logic [7:0] lastWr
);
    logic [19:0] addr_r = 20'h00000; // latched address
    logic [3:0] cnt_r = 4'h0; // cycles since the address strobe
    logic busy_r = 1'b0; // a bus cycle is open
    logic [7:0] held_r = 8'h00; // last byte put on the bus
    logic [7:0] memByte; // contents keyed to the address
    // pattern so that a wrong address shows up as wrong data
    assign memByte = addr_r[7:0] ^ addr_r[15:8] ^ {2{addr_r[19:16]}};
    // latch on the strobe's trailing edge; close when strobes are back up
    always @(posedge clk) begin
        if (ale) begin
            addr_r <= busPins;
            busy_r <= 1'b1;
            cnt_r <= 4'h0;
        end else if (busy_r) begin
            if (rdStrobe_n && wrStrobe_n && cnt_r > 4'h1)
                busy_r <= 1'b0;
            if (cnt_r != 4'hF)
                cnt_r <= cnt_r + 4'h1;
        end
        if (!wrStrobe_n)
            lastWr <= busPins[7:0];
        if (!rdStrobe_n)
            held_r <= memByte;
    end
    // not ready until the count has run, like a slow wait-state generator
    assign readyPin = (waitCycles == 4'h0) ||
        (busy_r && cnt_r >= waitCycles);
    // a released bus shows the inverse, so stale data cannot pass
    assign adIn = rdStrobe_n ? ~held_r : memByte;
endmodule : cbiu_mem_model
`default_nettype wire

// ### cbiu_pkg.sv
// cbiu_pkg: shared constants and types for the cpu bus interface unit
// assumes: single 100 MHz clock domain, synchronous active-high reset
package cbiu_pkg;
    // bus status encodings, high bit first
    localparam logic [2:0] STAT_INTA = 3'h0; // interrupt acknowledge
    localparam logic [2:0] STAT_IORD = 3'h1; // i/o read
    localparam logic [2:0] STAT_IOWR = 3'h2; // i/o write
    localparam logic [2:0] STAT_HALT = 3'h3; // halt
    localparam logic [2:0] STAT_CODE = 3'h4; // instruction fetch
    localparam logic [2:0] STAT_MRD = 3'h5; // memory read
    localparam logic [2:0] STAT_MWR = 3'h6; // memory write
    localparam logic [2:0] STAT_PASS = 3'h7; // passive
    // segment status encodings, high bit first
    localparam logic [1:0] SEG_EXTRA = 2'h0;
    localparam logic [1:0] SEG_STACK = 2'h1;
    localparam logic [1:0] SEG_CODE = 2'h2;
    localparam logic [1:0] SEG_DATA = 2'h3;
    // reset values and sizes
    localparam logic [15:0] CODE_SEG_RST = 16'hFFFF;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [2:0] QUEUE_DEPTH = 3'h4;
    localparam logic [19:0] VEC_TABLE_TOP = 20'h003FF;
    localparam int SHIFT_SEG = 4;
    // request from the instruction executor
    typedef struct packed {
        logic [2:0] kind;    // a STAT_* code, never CODE or PASS
        logic [1:0] seg;     // a SEG_* code
        logic [15:0] offset; // unrelocated offset
        logic [7:0] wdata;
    } cbiu_req_t;
    // pin bundle for address/status
    typedef struct packed {
        logic [19:0] addr;
        logic [2:0] stat;
        logic [1:0] segStat;
    } cbiu_bus_t;
endpackage : cbiu_pkg

// ### cbiu_reloc.sv
// cbiu_reloc: segment relocation adder
// assumes: purely combinational, caller registers the result
`timescale 1ns/1ps
`default_nettype none
module cbiu_reloc (
    input wire logic [15:0] segVal,
    input wire logic [15:0] offset,
    input wire logic isIo,
    output logic [19:0] phys
);
    // memory: base shifted by four plus offset, wraps at 20 bits
    wire [19:0] segBase = {segVal, 4'h0};
    wire [19:0] sum = segBase + {4'h0, offset};
    // i/o: upper nibble forced low
    assign phys = isIo ? {4'h0, offset} : sum;
endmodule : cbiu_reloc
`default_nettype wire

// ### cbiu_top.sv
// cbiu_top: bus cycle sequencer, prefetch queue and relocation
// assumes: pins arrive asynchronous and are synchronised here; the
// executor side is same-clock logic; bus pins are split as in/out/oe
//
// Contract
// - minimum mode aux status equals low status bit
// - all state static, clock may stop
// - single step by clock pulses alone
// - prefetch queue holds at most four bytes
// - executor gives offsets, unit relocates and runs bus
// - twenty-bit byte addresses
// - segments are 64K, 16-byte aligned
// - first fetch at FFFF0 after reset
// - low 1K is the 256-entry vector table
// - fetch uses code, stack refs use stack
// - string dest uses extra, data uses data
// - mode select picks strobes or encoded status
// - bus cycle at least four states
// - address T1, turnaround T2, data T3-T4; a write drives its data from T2
// - wait states between T3 and T4 until ready
// - idle states when no transfer needed
// - latch strobe pulses during T1
// - three status bits encode cycle kind
// - upper address lines carry status T2-T4
// - segment status pair encoding
// - one status bit shows interrupt enable
// - memory/io select low memory, high i/o
// - mode pin low maximum, high minimum
`timescale 1ns/1ps
`default_nettype none
module cbiu_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic readyPin,
    input wire logic systemModeSelectPin,
    input wire logic [7:0] adIn,
    input wire logic intEnable,
    input wire logic [15:0] codeSegIn,
    input wire logic codeSegLoad,
    input wire logic [15:0] stackSegIn,
    input wire logic [15:0] dataSegIn,
    input wire logic [15:0] extraSegIn,
    input wire logic reqValid,
    input wire cbiu_pkg::cbiu_req_t req,
    input wire logic queuePop,
    input wire logic queueFlush,
    output logic reqReady,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic [7:0] queueByte,
    output logic queueValid,
    output logic [7:0] adOut,
    output logic adOe,
    output logic [7:0] addrMid,
    output logic [3:0] addrHigh,
    output logic cycleStatusBitLow,
    output logic cycleStatusBitMid,
    output logic cycleStatusBitHigh,
    output logic auxStatusLine,
    output logic ale,
    output logic rdStrobe_n,
    output logic wrStrobe_n,
    output logic intaStrobe_n,
    output logic ioMemSel,
    output logic dtR
);
    // bus states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01, ST_T1 = 6'h02, ST_T2 = 6'h04,
        ST_T3 = 6'h08, ST_TW = 6'h10, ST_T4 = 6'h20
    } cbiu_state_t;

    // pin synchronisers, stage one read only by stage two
    logic rdySync1_r, rdySync2_r;
    logic modeSync1_r, modeSync2_r;
    logic [7:0] adSync1_r, adSync2_r;
    // sequencer state
    cbiu_state_t state_r, state_nxt;
    cbiu_pkg::cbiu_bus_t cyc_r; // latched cycle description
    logic [7:0] wdata_r;
    logic [15:0] codeSeg_r; // code segment base
    logic [15:0] pc_r;      // next prefetch offset
    logic [7:0] queue_r [4];
    logic [1:0] qHead_r, qTail_r;
    logic [2:0] qCount_r;
    logic flushPend_r; // drop the fetch in flight
    // outputs as registers
    logic rdValid_r, ale_r, adOe_r, rd_n_r, wr_n_r, inta_n_r;
    logic [7:0] rdData_r, adOut_r, addrMid_r;
    logic [3:0] addrHigh_r;
    logic [2:0] stat_r;
    logic ioSel_r, dtR_r;

    // mode pin: low is maximum, high is minimum
    wire minMode = modeSync2_r;
    wire busReady = rdySync2_r;

    // segment chooser: fetch always code, else by request
    function automatic logic [15:0] segOf(input logic [1:0] s,
        input logic [15:0] cs, input logic [15:0] ss,
        input logic [15:0] ds, input logic [15:0] es);
        case (s)
            cbiu_pkg::SEG_STACK: segOf = ss;
            cbiu_pkg::SEG_EXTRA: segOf = es;
            cbiu_pkg::SEG_DATA: segOf = ds;
            default: segOf = cs;
        endcase
    endfunction : segOf

    // i/o kinds take the i/o address form
    function automatic logic isIoKind(input logic [2:0] k);
        isIoKind = (k == cbiu_pkg::STAT_IORD) ||
            (k == cbiu_pkg::STAT_IOWR);
    endfunction : isIoKind

    // executor requests win; prefetch only while the queue has room
    wire takeReq = reqValid;
    // a fetch still on the bus already owns a slot, else a fifth slips in
    wire fetchOpen = (state_r != ST_IDLE) &&
        (cyc_r.stat == cbiu_pkg::STAT_CODE);
    wire [2:0] qUsed = qCount_r + {2'h0, fetchOpen};
    wire qRoom = (qUsed < cbiu_pkg::QUEUE_DEPTH) && !flushPend_r;
    // no fetch starts on a flush edge, its offset would be stale
    wire takeFetch = !reqValid && qRoom && !queueFlush;
    wire startCycle = (state_r == ST_IDLE || state_r == ST_T4) &&
        (takeReq || takeFetch);
    wire [2:0] newKind = takeReq ? req.kind : cbiu_pkg::STAT_CODE;
    wire [1:0] newSeg = takeReq ? req.seg : cbiu_pkg::SEG_CODE;
    wire [15:0] newOff = takeReq ? req.offset : pc_r;
    wire [15:0] selSeg = segOf(newSeg, codeSeg_r, stackSegIn,
        dataSegIn, extraSegIn);
    wire newIo = isIoKind(newKind);
    wire [19:0] newPhys;
    wire isRead = (cyc_r.stat == cbiu_pkg::STAT_IORD) ||
        (cyc_r.stat == cbiu_pkg::STAT_MRD) ||
        (cyc_r.stat == cbiu_pkg::STAT_CODE) ||
        (cyc_r.stat == cbiu_pkg::STAT_INTA);
    wire isWrite = (cyc_r.stat == cbiu_pkg::STAT_IOWR) ||
        (cyc_r.stat == cbiu_pkg::STAT_MWR);
    wire isFetch = cyc_r.stat == cbiu_pkg::STAT_CODE;
    wire endCycle = state_r == ST_T4;
    wire qPush = endCycle && isFetch && !flushPend_r &&
        !queueFlush;
    wire qPop = queuePop && (qCount_r != 3'h0) && !queueFlush;
    // upper lines: status nibble {upper, int enable, segment pair}
    wire [3:0] statNibble = {1'b0, intEnable, cyc_r.segStat};

    // relocation, memory and i/o forms
    cbiu_reloc uReloc (
        .segVal(selSeg),
        .offset(newOff),
        .isIo(newIo),
        .phys(newPhys)
    );

    // next bus state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (startCycle) state_nxt = ST_T1;
            ST_T1: state_nxt = ST_T2;
            ST_T2: state_nxt = ST_T3;
            ST_T3: state_nxt = busReady ? ST_T4 : ST_TW;
            ST_TW: state_nxt = busReady ? ST_T4 : ST_TW;
            ST_T4: state_nxt = startCycle ? ST_T1 : ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // synchronisers; clock enable low freezes every flop
    always_ff @(posedge clk) begin
        if (ce) begin
            rdySync1_r <= readyPin;
            rdySync2_r <= rdySync1_r;
            modeSync1_r <= systemModeSelectPin;
            modeSync2_r <= modeSync1_r;
            adSync1_r <= adIn;
            adSync2_r <= adSync1_r;
        end
    end

    // sequencer and cycle latch
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cyc_r <= '{addr: 20'h0, stat: cbiu_pkg::STAT_PASS,
                segStat: cbiu_pkg::SEG_CODE};
            wdata_r <= 8'h00;
        end else if (ce) begin
            state_r <= state_nxt;
            if (startCycle) begin
                cyc_r <= '{addr: newPhys, stat: newKind,
                    segStat: newSeg};
                wdata_r <= req.wdata;
            end
        end
    end

    // code segment and prefetch pointer; reset points at FFFF0
    always_ff @(posedge clk) begin
        if (rst) begin
            codeSeg_r <= cbiu_pkg::CODE_SEG_RST;
            pc_r <= cbiu_pkg::PC_RST;
            flushPend_r <= 1'b0;
        end else if (ce) begin
            if (codeSegLoad) codeSeg_r <= codeSegIn;
            if (queueFlush) pc_r <= codeSegLoad ? cbiu_pkg::PC_RST : pc_r;
            else if (startCycle && takeFetch) pc_r <= pc_r + 16'h0001;
            // a fetch already on the bus is discarded after a flush
            // in T4 the push is already blocked, so no later drop is owed
            if (queueFlush && isFetch && state_r != ST_IDLE &&
                    state_r != ST_T4)
                flushPend_r <= 1'b1;
            else if (endCycle) flushPend_r <= 1'b0;
        end
    end

    // prefetch queue, at most four bytes
    always_ff @(posedge clk) begin
        if (rst || (ce && queueFlush)) begin
            qHead_r <= 2'h0;
            qTail_r <= 2'h0;
            qCount_r <= 3'h0;
        end else if (ce) begin
            if (qPush) begin
                queue_r[qTail_r] <= adSync2_r;
                qTail_r <= qTail_r + 2'h1;
            end
            if (qPop) qHead_r <= qHead_r + 2'h1;
            qCount_r <= qCount_r + {2'h0, qPush} - {2'h0, qPop};
        end
    end

    // pin outputs, registered
    always_ff @(posedge clk) begin
        if (rst) begin
            ale_r <= 1'b0;
            adOe_r <= 1'b0;
            adOut_r <= 8'h00;
            addrMid_r <= 8'h00;
            addrHigh_r <= 4'h0;
            stat_r <= cbiu_pkg::STAT_PASS;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            inta_n_r <= 1'b1;
            ioSel_r <= 1'b0;
            dtR_r <= 1'b0;
            rdValid_r <= 1'b0;
            rdData_r <= 8'h00;
        end else if (ce) begin
            ale_r <= state_nxt == ST_T1;
            // read data leaves the synchroniser during T4, taken at its end
            rdValid_r <= endCycle && isRead && !isFetch;
            rdData_r <= endCycle ? adSync2_r : rdData_r;
            case (state_nxt)
                ST_T1: begin
                    adOut_r <= startCycle ? newPhys[7:0] : adOut_r;
                    addrMid_r <= startCycle ? newPhys[15:8] : addrMid_r;
                    addrHigh_r <= startCycle ? newPhys[19:16] : 4'h0;
                    adOe_r <= 1'b1;
                    stat_r <= newKind;
                    ioSel_r <= newIo;
                    dtR_r <= !(newKind == cbiu_pkg::STAT_IORD ||
                        newKind == cbiu_pkg::STAT_MRD ||
                        newKind == cbiu_pkg::STAT_CODE ||
                        newKind == cbiu_pkg::STAT_INTA);
                end
                ST_T2, ST_T3, ST_TW: begin
                    addrHigh_r <= statNibble;
                    adOe_r <= isWrite;
                    adOut_r <= isWrite ? wdata_r : adOut_r;
                    rd_n_r <= !(minMode && isRead &&
                        cyc_r.stat != cbiu_pkg::STAT_INTA);
                    wr_n_r <= !(minMode && isWrite);
                    inta_n_r <= !(minMode &&
                        cyc_r.stat == cbiu_pkg::STAT_INTA);
                    // status goes passive in T3 when ready is up in T2, else only in T4
                    stat_r <= (state_nxt == ST_T2) ? stat_r :
                        (busReady ? cbiu_pkg::STAT_PASS : stat_r);
                end
                ST_T4: begin
                    addrHigh_r <= statNibble;
                    rd_n_r <= 1'b1;
                    wr_n_r <= 1'b1;
                    inta_n_r <= 1'b1;
                    stat_r <= cbiu_pkg::STAT_PASS;
                end
                default: begin
                    adOe_r <= 1'b0;
                    stat_r <= cbiu_pkg::STAT_PASS;
                end
            endcase
        end
    end

    // outputs, from flops except reqReady, which is combinational
    assign adOut = adOut_r;
    assign adOe = adOe_r;
    assign addrMid = addrMid_r;
    assign addrHigh = addrHigh_r;
    // maximum mode: encoded status drives the bus controller
    assign cycleStatusBitLow = minMode ? 1'b1 : stat_r[0];
    assign cycleStatusBitMid = minMode ? 1'b1 : stat_r[1];
    assign cycleStatusBitHigh = minMode ? 1'b1 : stat_r[2];
    assign auxStatusLine = stat_r[0];
    assign ale = ale_r;
    assign rdStrobe_n = rd_n_r;
    assign wrStrobe_n = wr_n_r;
    assign intaStrobe_n = inta_n_r;
    assign ioMemSel = ioSel_r;
    assign dtR = dtR_r;
    assign rdValid = rdValid_r;
    assign rdData = rdData_r;
    assign queueByte = queue_r[qHead_r];
    assign queueValid = qCount_r != 3'h0;
    assign reqReady = startCycle && takeReq;

    // address in vector table is flagged for the vecTable_a assertion
    wire inVecTable = cyc_r.addr <= cbiu_pkg::VEC_TABLE_TOP;

    // a cycle steps T1 to T2 to T3 on enabled edges; a frozen clock waits
    sequence seqInT1;
        ce && state_r == ST_T1;
    endsequence
    sequence seqInT2;
        ce && state_r == ST_T2;
    endsequence
    busOrder_a: assert property (@(posedge clk) disable iff (rst)
        seqInT1 |=> state_r == ST_T2)
        else $error("bus cycle order broken");
    busStep_a: assert property (@(posedge clk) disable iff (rst)
        seqInT2 |=> state_r == ST_T3)
        else $error("bus cycle step broken");
    waitHold_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T3 && !busReady) |=> state_r == ST_TW)
        else $error("wait state missing");
    aleT1_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T1) |-> ale_r)
        else $error("latch strobe not in T1");
    auxEq_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T1) |-> auxStatusLine == cyc_r.stat[0])
        else $error("aux status mismatch");
    ioHigh_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T1 && isIoKind(cyc_r.stat)) |->
        addrHigh_r == 4'h0)
        else $error("i/o upper lines not low");
    ioSel_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T2) |-> ioSel_r == isIoKind(cyc_r.stat))
        else $error("memory/io select wrong");
    queueMax_a: assert property (@(posedge clk) disable iff (rst)
        qCount_r <= cbiu_pkg::QUEUE_DEPTH)
        else $error("queue over four bytes");
    statusUp_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T2) |-> addrHigh_r[2] == $past(intEnable))
        else $error("status nibble not on upper lines");
    vecTable_a: assert property (@(posedge clk) disable iff (rst)
        (ce && state_r == ST_T1 && inVecTable) |->
        {addrHigh_r, addrMid_r[7:2]} == 10'h000)
        else $error("vector table bound wrong");
endmodule : cbiu_top
`default_nettype wire

// ### tb_cpu_bus_interface_unit.sv
// tb_cpu_bus_interface_unit: self-checking bench for the bus unit
// assumes: cbiu_pkg, cbiu_top and cbiu_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_bus_interface_unit;
    logic clk = 1'b0; // 100 MHz
    logic rst = 1'b1;
    logic ce = 1'b1; // low freezes the unit
    logic systemModeSelectPin = 1'b1; // high is minimum mode
    logic intEnable = 1'b0;
    logic [15:0] stackSegIn = 16'h2000;
    logic [15:0] dataSegIn = 16'h1234;
    logic [15:0] extraSegIn = 16'h1000;
    logic reqValid = 1'b0;
    cbiu_pkg::cbiu_req_t req = '0;
    logic queuePop = 1'b0;
    logic [3:0] waitCycles = 4'h0; // slave wait request
    logic readyPin, reqReady, rdValid, queueValid, adOe, ale, ioMemSel, dtR;
    logic [7:0] adIn, rdData, queueByte, adOut, addrMid, lastWr;
    logic [3:0] addrHigh;
    logic cycleStatusBitHigh, cycleStatusBitMid, cycleStatusBitLow;
    logic auxStatusLine, rdStrobe_n, wrStrobe_n;
    logic [19:0] busPins; // address lines as a whole
    logic [19:0] seenAddr; // captured by bus_op
    logic [3:0] seenHigh;
    logic [2:0] seenStat;
    logic [7:0] seenData;
    logic seenAux, seenIo, seenDir;
    int lowLen; // strobe-low cycles of the last transfer
    int nErrors = 0;
    int checked = 0;
    assign busPins = {addrHigh, addrMid, adOut};
    cbiu_top cbiu_top_i (.clk, .rst, .ce, .readyPin, .systemModeSelectPin,
        .adIn, .intEnable, .codeSegIn(16'hFFFF), .codeSegLoad(1'b0),
        .stackSegIn, .dataSegIn, .extraSegIn, .reqValid, .req, .queuePop,
        .queueFlush(1'b0), .reqReady, .rdData, .rdValid, .queueByte,
        .queueValid, .adOut, .adOe, .addrMid, .addrHigh, .cycleStatusBitLow,
        .cycleStatusBitMid, .cycleStatusBitHigh, .auxStatusLine, .ale,
        .rdStrobe_n, .wrStrobe_n, .intaStrobe_n(), .ioMemSel, .dtR);
    cbiu_mem_model cbiu_mem_model_i (.clk, .ale, .busPins, .rdStrobe_n,
        .wrStrobe_n, .waitCycles, .adIn, .readyPin, .lastWr);
    // clock
    initial begin
        forever #5 clk = ~clk;
    end
    // expected memory contents, same pattern as the slave
    function automatic logic [7:0] mem_byte(input logic [19:0] a);
        return a[7:0] ^ a[15:8] ^ {2{a[19:16]}};
    endfunction : mem_byte
    task automatic test_done;
        if (nErrors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [19:0] e,
            input logic [19:0] s);
        checked++;
        if (s !== e) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", name, e, s);
        end
    endtask : chk
    // a bounded wait ran out
    task automatic timeout;
        chk("handshake", 20'h1, 20'h0);
        test_done();
    endtask : timeout
    // one executor request, held until taken, watched to its T4
    task automatic bus_op(input logic [2:0] kind, input logic [1:0] seg,
            input logic [15:0] off, input logic [7:0] wd);
        int i;
        bit rd;
        rd = kind == cbiu_pkg::STAT_IORD || kind == cbiu_pkg::STAT_MRD;
        @(posedge clk);
        req <= '{kind: kind, seg: seg, offset: off, wdata: wd};
        reqValid <= 1'b1;
        for (i = 0; i < 200 && reqReady !== 1'b1; i++)
            @(negedge clk);
        if (i == 200)
            timeout();
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk);
        chk("ale", 20'h1, {19'h0, ale});
        seenAddr = busPins;
        seenStat = {cycleStatusBitHigh, cycleStatusBitMid, cycleStatusBitLow};
        seenAux = auxStatusLine;
        seenIo = ioMemSel;
        lowLen = 0;
        for (i = 0; i < 60; i++) begin
            @(negedge clk);
            if (i == 0) begin
                seenHigh = addrHigh;
                seenDir = dtR;
            end
            if (!rdStrobe_n || !wrStrobe_n)
                lowLen++;
            if (rd ? rdValid === 1'b1 : i == 2)
                break;
        end
        if (i == 60)
            timeout();
        seenData = rdData;
    endtask : bus_op
    // queue fills to four bytes from the reset address, then idles
    task automatic t_prefetch;
        int i;
        int n;
        n = 0;
        for (i = 0; i < 80; i++) begin
            @(negedge clk);
            if (ale === 1'b1) begin
                chk("fetch addr", 20'hFFFF0 + n[19:0], busPins);
                chk("fetch aux", 20'h0, {19'h0, auxStatusLine});
                n++;
            end
        end
        chk("fetch count", 20'h4, n[19:0]);
        for (i = 0; i < 4; i++) begin
            @(negedge clk);
            chk("queue", {11'h0, 1'b1, mem_byte(20'hFFFF0 + i[19:0])},
                {11'h0, queueValid, queueByte});
            @(posedge clk);
            queuePop <= 1'b1;
            @(posedge clk);
            queuePop <= 1'b0;
        end
    endtask : t_prefetch
    // every segment code, offsets 0010 and FFFF, then the vector table
    task automatic t_segments;
        logic [15:0] base [4];
        logic [19:0] e;
        logic [15:0] off;
        int s;
        base = '{16'h1000, 16'h2000, 16'hFFFF, 16'h1234};
        for (s = 0; s < 9; s++) begin
            off = s[2] ? 16'hFFFF : 16'h0010;
            e = {base[s[1:0]], 4'h0} + {4'h0, off};
            if (s == 8) begin
                off = 16'h03FF;
                e = 20'h003FF;
            end
            @(posedge clk);
            if (s == 8)
                extraSegIn <= 16'h0000;
            intEnable <= s[0];
            bus_op(cbiu_pkg::STAT_MRD, s[1:0], off, 8'h00);
            chk("addr", e, seenAddr);
            chk("status", {13'h0, s[0], s[1:0], 4'h7},
                {12'h0, seenHigh, 1'b0, seenStat});
            chk("aux io", 20'h2, {18'h0, seenAux, seenIo});
            chk("data", {12'h0, mem_byte(e)}, {12'h0, seenData});
            chk("strobe len", 20'h2, lowLen[19:0]);
        end
        @(posedge clk);
        extraSegIn <= 16'h1000;
    endtask : t_segments
    // i/o write then read, upper lines low, select high on the write
    task automatic t_io;
        bus_op(cbiu_pkg::STAT_IOWR, cbiu_pkg::SEG_DATA, 16'hABCD, 8'h5A);
        chk("io addr", 20'h0ABCD, seenAddr);
        chk("io sel dir aux", 20'h6, {17'h0, seenIo, seenDir, seenAux});
        chk("wr data", 20'h5A, {12'h0, lastWr});
        bus_op(cbiu_pkg::STAT_IORD, cbiu_pkg::SEG_DATA, 16'hFFFF, 8'h00);
        chk("io addr", 20'h0FFFF, seenAddr);
        chk("io data", {12'h0, mem_byte(20'h0FFFF)}, {12'h0, seenData});
    endtask : t_io
    // a slow slave stretches the strobe by wait states
    task automatic t_waits;
        waitCycles <= 4'h6;
        bus_op(cbiu_pkg::STAT_MRD, cbiu_pkg::SEG_DATA, 16'h0100, 8'h00);
        chk("wait data", {12'h0, mem_byte(20'h12440)}, {12'h0, seenData});
        chk("stretched", 20'h1, {19'h0, lowLen > 4 && lowLen < 13});
        waitCycles <= 4'h0;
    endtask : t_waits
    // frozen clock holds the address lines and read strobe; single enabled edges step states
    task automatic t_freeze;
        logic [19:0] snap;
        int i;
        @(posedge clk);
        queuePop <= 1'b1;
        @(posedge clk);
        queuePop <= 1'b0;
        for (i = 0; i < 40 && ale !== 1'b1; i++)
            @(negedge clk);
        if (i == 40)
            timeout();
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        snap = busPins;
        repeat (20) @(negedge clk);
        chk("frozen", {snap, 1'b0}, {busPins, rdStrobe_n});
        for (i = 0; i < 2; i++) begin
            @(posedge clk);
            ce <= 1'b1;
            @(posedge clk);
            ce <= 1'b0;
            repeat (3) @(negedge clk);
            chk("stepped strobe", i[19:0], {19'h0, rdStrobe_n});
        end
        @(posedge clk);
        ce <= 1'b1;
    endtask : t_freeze
    // maximum mode: six status codes, all but fetch and passive, no read or write strobes, passive when idle
    task automatic t_max;
        logic [2:0] kinds [6];
        int k;
        kinds = '{cbiu_pkg::STAT_INTA, cbiu_pkg::STAT_IORD,
            cbiu_pkg::STAT_IOWR, cbiu_pkg::STAT_HALT, cbiu_pkg::STAT_MRD,
            cbiu_pkg::STAT_MWR};
        @(posedge clk);
        systemModeSelectPin <= 1'b0;
        repeat (4) @(posedge clk);
        for (k = 0; k < 6; k++) begin
            bus_op(kinds[k], cbiu_pkg::SEG_DATA, 16'h0020, 8'h33);
            chk("max status", {17'h0, kinds[k]}, {17'h0, seenStat});
            chk("max strobes", 20'h0, lowLen[19:0]);
        end
        repeat (8) @(negedge clk);
        chk("passive", 20'h7, {17'h0, cycleStatusBitHigh,
            cycleStatusBitMid, cycleStatusBitLow});
        @(posedge clk);
        systemModeSelectPin <= 1'b1;
    endtask : t_max
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_prefetch();
        t_segments();
        t_io();
        t_waits();
        t_freeze();
        t_max();
        test_done();
    end
endmodule : tb_cpu_bus_interface_unit
`default_nettype wire
